// file: pkg/b2e_pkg.sv
// Constants and types shared by the 2D block transfer engine
package b2e_pkg;
  localparam int DW = 16;
  localparam int AW = 21;
  localparam int CW = 10;
  localparam int WIN_BIT = 20;
  localparam int FIFO_DEPTH = 8;
  localparam logic [4:0] LEFT_NONE = 5'h00;
  localparam logic [4:0] LEFT_ONE = 5'h01;
  localparam logic [4:0] LEFT_BYTES = 5'h02;
  localparam logic [4:0] LEFT_BYTE_BITS = 5'h08;
  localparam logic [4:0] LEFT_WORD_BITS = 5'h10;
  localparam logic [AW-1:0] STEP_BYTE = 21'h000001;
  localparam logic [AW-1:0] STEP_WORD = 21'h000002;
  localparam logic [AW-1:0] PAT_MASK8 = 21'h00003f;
  localparam logic [AW-1:0] PAT_MASK16 = 21'h00007f;
  localparam logic [CW-1:0] CNT_ONE = 10'h001;
  localparam logic [2:0] PAT_LAST = 3'h7;
  localparam logic [1:0] BE_LOW = 2'h1;
  localparam logic [1:0] BE_HIGH = 2'h2;
  localparam logic [1:0] BE_BOTH = 2'h3;
  localparam logic [7:0] BYTE_ZERO = 8'h00;

  typedef enum logic [3:0] {
    OP_WRITE = 4'h0,
    OP_READ = 4'h1,
    OP_MOVE = 4'h2,
    OP_SOLID = 4'h3,
    OP_PAT = 4'h4,
    OP_TPAT = 4'h5,
    OP_TWRITE = 4'h6,
    OP_TMOVE = 4'h7,
    OP_EXP = 4'h8,
    OP_MEXP = 4'h9
  } b2e_op_type;

  typedef enum logic [2:0] {
    S_IDLE = 3'b000,
    S_SRC = 3'b001,
    S_SRD = 3'b010,
    S_DRD = 3'b011,
    S_DWR = 3'b100,
    S_OUT = 3'b101,
    S_NEXT = 3'b110,
    S_DONE = 3'b111
  } b2e_state_type;

  typedef struct packed {
    b2e_op_type op;
    logic [3:0] rop;
    logic bpp16;
    logic dirNeg;
    logic srcLin;
    logic dstLin;
    logic bgTransp;
    logic [AW-1:0] srcAddr;
    logic [AW-1:0] dstAddr;
    logic [AW-1:0] srcPitch;
    logic [AW-1:0] dstPitch;
    logic [CW-1:0] width;
    logic [CW-1:0] height;
    logic [DW-1:0] fg;
    logic [DW-1:0] bg;
  } b2e_cfg_type;

  typedef struct packed {
    logic we;
    logic [1:0] be;
    logic [AW-1:0] addr;
    logic [DW-1:0] wdata;
  } b2e_mem_type;
endpackage

// file: hdl/b2e_fifo.sv
// Host write data FIFO of the block transfer engine
`timescale 1ns/1ps
`default_nettype none
module b2e_fifo #(
  parameter int W = 16,
  parameter int DEPTH = 8
)
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // Fill side
  input wire logic inValid,
  output logic inReady,
  input wire logic [W-1:0] inData,
  // Drain side
  output logic outValid,
  input wire logic outReady,
  output logic [W-1:0] outData
);
  localparam int PW = $clog2(DEPTH);
  logic [W-1:0] mem [DEPTH];
  logic [PW-1:0] wp_r;
  logic [PW-1:0] rp_r;
  logic [PW:0] cnt_r;
  logic [PW:0] cnt_nxt;
  logic push;
  logic pop;

  assign outValid = (cnt_r != '0);
  assign outData = mem[rp_r];
  assign push = inValid && inReady;
  assign pop = outValid && outReady;
  assign cnt_nxt = cnt_r + (PW+1)'(push) - (PW+1)'(pop);

  always_ff @(posedge core_clk)
  begin
    if (push)
    begin
      mem[wp_r] <= inData;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wp_r <= '0;
      rp_r <= '0;
      cnt_r <= '0;
      inReady <= 1'b0;
    end
    else
    begin
      wp_r <= wp_r + PW'(push);
      rp_r <= rp_r + PW'(pop);
      cnt_r <= cnt_nxt;
      inReady <= (cnt_nxt < (PW+1)'(DEPTH));
    end
  end
endmodule
`default_nettype wire

// file: hdl/b2e_engine.sv
// 2D block transfer engine: host window, pixel sequencer, memory port
`timescale 1ns/1ps
`default_nettype none
// Function
// - Move pixels over a 16-bit path at 8 or 16 bits per pixel.
// - Rectangular or linear addressing; only plain move may step negative.
// - Host reaches the engine through its own dedicated data window.
// - Host write combines host and destination data by one of 16 ROPs.
// - Move applies the same 16 ROPs in either direction.
// - Read returns display memory to the host with no ROP.
// - Solid fill writes foreground colour; low byte only at 8 bpp.
// - Pattern fill tiles an 8x8 pattern stored contiguously off screen.
// - Low source start address bits pick the first pattern pixel.
// - Pattern fill follows line ends and wraps after the last row.
// - Transparent pattern fill skips pixels matching the background key.
// - Transparent write skips host pixels matching the background key.
// - Transparent move is positive only and skips key-coloured pixels.
// - Expansion: one gives foreground, zero gives background colour.
// - With background transparency zero bits leave destination unchanged.
// - Host expansion data arrives as words; line end discards leftover bits.
// - Expansion uses low byte first, each byte from bit 7 down.
// - Host expansion accepts any alignment, positive direction only.
// - Move expansion reads byte-aligned off-screen data, positive only.
// - Window answers at every even address with address bit 20 set.
module b2e_engine
  import b2e_pkg::*;
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // Operation control
  input wire logic start,
  input wire b2e_cfg_type cfg,
  output logic busy,
  // Host data window
  input wire logic hostWe,
  input wire logic hostRe,
  input wire logic [AW-1:0] hostAddr,
  input wire logic [DW-1:0] hostWdata,
  output logic hostWrReady,
  output logic hostRdValid,
  output logic [DW-1:0] hostRdata,
  // Display buffer
  output logic memReq,
  output var b2e_mem_type memCmd,
  input wire logic memAck,
  input wire logic [DW-1:0] memRdata
);
  b2e_cfg_type c_r;
  b2e_state_type state_r;
  logic [AW-1:0] srcAddr_r;
  logic [AW-1:0] dstAddr_r;
  logic [AW-1:0] srcLine_r;
  logic [AW-1:0] dstLine_r;
  logic [CW-1:0] xCnt_r;
  logic [CW-1:0] yCnt_r;
  logic [2:0] patX_r;
  logic [2:0] patY_r;
  logic [2:0] patX0_r;
  logic [DW-1:0] srcWord_r;
  logic [DW-1:0] pix_r;
  logic [DW-1:0] dstPix_r;
  logic [4:0] srcLeft_r;
  logic curBit_r;
  logic [7:0] outLow_r;
  logic outHalf_r;
  logic winHit;
  logic fifoPush;
  logic fifoValid;
  logic fifoPop;
  logic [DW-1:0] fifoData;
  logic isHost;
  logic isExp;
  logic useRop;
  logic isTrans;
  logic isPat;
  logic isRead;
  logic srcMem;
  logic consume;
  logic memDone;
  logic lineEnd;
  logic lastPix;
  logic keyHit;
  logic skipWr;
  logic memIssue;
  logic [AW-1:0] step;
  logic [AW-1:0] patAddr;
  logic [AW-1:0] srcNextLine;
  logic [AW-1:0] dstNextLine;
  logic [7:0] lane;
  logic [DW-1:0] ropOut;
  logic [DW-1:0] wPix;
  logic [5:0] patIdx;
  logic [5:0] patIdx0;

  function automatic logic [AW-1:0] stepAddr(input logic [AW-1:0] a,
    input logic [AW-1:0] d, input logic neg);
    stepAddr = neg ? a - d : a + d;
  endfunction

  // Decode of the host window, independent of the register space
  assign winHit = hostAddr[WIN_BIT] && !hostAddr[0];
  assign fifoPush = hostWe && winHit;

  b2e_fifo #(
    .W(DW),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .inValid(fifoPush),
    .inReady(hostWrReady),
    .inData(hostWdata),
    .outValid(fifoValid),
    .outReady(fifoPop),
    .outData(fifoData)
  );

  assign isHost = (c_r.op == OP_WRITE) || (c_r.op == OP_TWRITE) ||
    (c_r.op == OP_EXP);
  assign isExp = (c_r.op == OP_EXP) || (c_r.op == OP_MEXP);
  assign useRop = (c_r.op == OP_WRITE) || (c_r.op == OP_MOVE) ||
    (c_r.op == OP_PAT);
  assign isTrans = (c_r.op == OP_TPAT) || (c_r.op == OP_TWRITE) ||
    (c_r.op == OP_TMOVE);
  assign isPat = (c_r.op == OP_PAT) || (c_r.op == OP_TPAT);
  assign isRead = (c_r.op == OP_READ);
  assign srcMem = (c_r.op == OP_MOVE) || (c_r.op == OP_TMOVE) || isRead;
  assign consume = (isHost || (c_r.op == OP_MEXP)) &&
    (srcLeft_r != LEFT_NONE);
  assign fifoPop = (state_r == S_SRC) && isHost &&
    (srcLeft_r == LEFT_NONE) && fifoValid;
  assign memDone = memReq && memAck;
  assign lineEnd = (xCnt_r == c_r.width - CNT_ONE);
  assign lastPix = lineEnd && (yCnt_r == c_r.height - CNT_ONE);
  assign step = c_r.bpp16 ? STEP_WORD : STEP_BYTE;
  assign lane = memCmd.addr[0] ? memRdata[15:8] : memRdata[7:0];
  assign srcNextLine = stepAddr(srcLine_r, c_r.srcPitch, c_r.dirNeg);
  assign dstNextLine = stepAddr(dstLine_r, c_r.dstPitch, c_r.dirNeg);

  // Pattern pixel address inside the 64 or 128 byte tile
  assign patIdx = {patY_r, patX_r};
  assign patAddr = c_r.bpp16 ?
    ((c_r.srcAddr & ~PAT_MASK16) | AW'({patIdx, 1'b0})) :
    ((c_r.srcAddr & ~PAT_MASK8) | AW'(patIdx));
  assign patIdx0 = cfg.bpp16 ? 6'((cfg.srcAddr & PAT_MASK16) >> 1) :
    6'(cfg.srcAddr & PAT_MASK8);

  for (genvar i = 0; i < DW; i++)
  begin : g_rop
    assign ropOut[i] = c_r.rop[{pix_r[i], dstPix_r[i]}];
  end

  assign keyHit = c_r.bpp16 ? (pix_r == c_r.bg) :
    (pix_r[7:0] == c_r.bg[7:0]);
  assign skipWr = (isTrans && keyHit) ||
    (isExp && !curBit_r && c_r.bgTransp);
  assign wPix = useRop ? ropOut : pix_r;
  assign memIssue = (state_r == S_SRD) || (state_r == S_DRD) ||
    ((state_r == S_DWR) && !skipWr);

  // Sequencer and busy flag
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_r <= S_IDLE;
      busy <= 1'b0;
    end
    else
    begin
      unique case (state_r)
        S_IDLE:
        begin
          if (start)
          begin
            busy <= 1'b1;
            state_r <= S_SRC;
          end
        end
        S_SRC:
        begin
          if (c_r.op == OP_SOLID)
            state_r <= S_DWR;
          else if (consume)
            state_r <= useRop ? S_DRD : S_DWR;
          else if (!isHost)
            state_r <= S_SRD;
        end
        S_SRD:
        begin
          if (memDone)
          begin
            if (c_r.op == OP_MEXP)
              state_r <= S_SRC;
            else if (isRead)
              state_r <= S_OUT;
            else
              state_r <= useRop ? S_DRD : S_DWR;
          end
        end
        S_DRD:
        begin
          if (memDone)
            state_r <= S_DWR;
        end
        S_DWR:
        begin
          if (skipWr || memDone)
            state_r <= S_NEXT;
        end
        S_OUT:
        begin
          if (!hostRdValid)
            state_r <= S_NEXT;
        end
        S_NEXT:
        begin
          if (!lastPix)
            state_r <= S_SRC;
          else if (isRead)
            state_r <= S_DONE;
          else
          begin
            busy <= 1'b0;
            state_r <= S_IDLE;
          end
        end
        S_DONE:
        begin
          if (!hostRdValid)
          begin
            busy <= 1'b0;
            state_r <= S_IDLE;
          end
        end
      endcase
    end
  end

  // Source pixel fetch, bit and byte unpacking
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      c_r <= '0;
      srcWord_r <= '0;
      srcLeft_r <= LEFT_NONE;
      pix_r <= '0;
      dstPix_r <= '0;
      curBit_r <= 1'b0;
    end
    else if (state_r == S_IDLE && start)
    begin
      c_r <= cfg;
      c_r.dirNeg <= cfg.dirNeg &&
        (cfg.op == OP_MOVE);
      srcLeft_r <= LEFT_NONE;
    end
    else if (fifoPop)
    begin
      srcWord_r <= {fifoData[7:0], fifoData[15:8]};
      srcLeft_r <= isExp ? LEFT_WORD_BITS :
        (c_r.bpp16 ? LEFT_ONE : LEFT_BYTES);
    end
    else if (state_r == S_SRC && consume)
    begin
      curBit_r <= srcWord_r[DW-1];
      if (isExp)
        pix_r <= srcWord_r[DW-1] ? c_r.fg : c_r.bg;
      else if (c_r.bpp16)
        pix_r <= {srcWord_r[7:0], srcWord_r[15:8]};
      else
        pix_r <= {BYTE_ZERO, srcWord_r[15:8]};
      srcWord_r <= isExp ? srcWord_r << 1 : srcWord_r << 8;
      srcLeft_r <= srcLeft_r - LEFT_ONE;
    end
    else if (state_r == S_SRC && c_r.op == OP_SOLID)
      pix_r <= c_r.fg;
    else if (state_r == S_SRD && memDone)
    begin
      if (c_r.op == OP_MEXP)
      begin
        srcWord_r <= {lane, BYTE_ZERO};
        srcLeft_r <= LEFT_BYTE_BITS;
      end
      else
        pix_r <= c_r.bpp16 ? memRdata : {BYTE_ZERO, lane};
    end
    else if (state_r == S_DRD && memDone)
      dstPix_r <= c_r.bpp16 ? memRdata : {BYTE_ZERO, lane};
    else if (state_r == S_NEXT && lineEnd && isExp)
      srcLeft_r <= LEFT_NONE;
  end

  // Address walk over rectangle, line and pattern tile
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      srcAddr_r <= '0;
      dstAddr_r <= '0;
      srcLine_r <= '0;
      dstLine_r <= '0;
      xCnt_r <= '0;
      yCnt_r <= '0;
      patX_r <= '0;
      patY_r <= '0;
      patX0_r <= '0;
    end
    else if (state_r == S_IDLE && start)
    begin
      srcAddr_r <= cfg.srcAddr;
      srcLine_r <= cfg.srcAddr;
      dstAddr_r <= cfg.dstAddr;
      dstLine_r <= cfg.dstAddr;
      xCnt_r <= '0;
      yCnt_r <= '0;
      patX_r <= patIdx0[2:0];
      patX0_r <= patIdx0[2:0];
      patY_r <= patIdx0[5:3];
    end
    else if (state_r == S_SRD && memDone && c_r.op == OP_MEXP)
      srcAddr_r <= srcAddr_r + STEP_BYTE;
    else if (state_r == S_NEXT && lineEnd)
    begin
      xCnt_r <= '0;
      yCnt_r <= yCnt_r + CNT_ONE;
      patX_r <= patX0_r;
      patY_r <= patY_r + 3'h1;
      if (c_r.dstLin)
        dstAddr_r <= stepAddr(dstAddr_r, step, c_r.dirNeg);
      else
      begin
        dstLine_r <= dstNextLine;
        dstAddr_r <= dstNextLine;
      end
      if (srcMem && c_r.srcLin)
        srcAddr_r <= stepAddr(srcAddr_r, step, c_r.dirNeg);
      else if ((srcMem || c_r.op == OP_MEXP) && !c_r.srcLin)
      begin
        srcLine_r <= srcNextLine;
        srcAddr_r <= srcNextLine;
      end
    end
    else if (state_r == S_NEXT)
    begin
      xCnt_r <= xCnt_r + CNT_ONE;
      patX_r <= patX_r + 3'h1;
      dstAddr_r <= stepAddr(dstAddr_r, step, c_r.dirNeg);
      if (srcMem)
        srcAddr_r <= stepAddr(srcAddr_r, step, c_r.dirNeg);
    end
  end

  // Display buffer port: request held until acknowledged
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      memReq <= 1'b0;
      memCmd <= '0;
    end
    else if (memDone)
      memReq <= 1'b0;
    else if (!memReq && memIssue)
    begin
      memReq <= 1'b1;
      memCmd.we <= (state_r == S_DWR);
      if (state_r == S_SRD)
        memCmd.addr <= isPat ? patAddr : srcAddr_r;
      else
        memCmd.addr <= dstAddr_r;
      if (c_r.bpp16)
        memCmd.be <= BE_BOTH;
      else if ((state_r == S_SRD) ? (isPat ? patAddr[0] : srcAddr_r[0]) :
        dstAddr_r[0])
        memCmd.be <= BE_HIGH;
      else
        memCmd.be <= BE_LOW;
      memCmd.wdata <= c_r.bpp16 ? wPix : {wPix[7:0], wPix[7:0]};
    end
  end

  // Read data packing toward the host, low byte first at 8 bpp
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      hostRdValid <= 1'b0;
      hostRdata <= '0;
      outLow_r <= '0;
      outHalf_r <= 1'b0;
    end
    else if (state_r == S_IDLE && start)
      outHalf_r <= 1'b0;
    else if (state_r == S_OUT && !hostRdValid)
    begin
      if (c_r.bpp16 || outHalf_r || lastPix)
      begin
        hostRdValid <= 1'b1;
        outHalf_r <= 1'b0;
        if (c_r.bpp16)
          hostRdata <= pix_r;
        else if (outHalf_r)
          hostRdata <= {pix_r[7:0], outLow_r};
        else
          hostRdata <= {BYTE_ZERO, pix_r[7:0]};
      end
      else
      begin
        outLow_r <= pix_r[7:0];
        outHalf_r <= 1'b1;
      end
    end
    else if (hostRe && winHit && hostRdValid)
      hostRdValid <= 1'b0;
  end

  chk_busy_start: assert property (@(posedge core_clk)
    disable iff (!rst_n)
    (state_r == S_IDLE && start) |=> busy && state_r == S_SRC)
    else $error("busy not raised at start");

  chk_busy_end: assert property (@(posedge core_clk)
    disable iff (!rst_n)
    (state_r == S_NEXT && lastPix && !isRead) |=>
    !busy && state_r == S_IDLE)
    else $error("busy not dropped after last write");

  chk_neg_move: assert property (@(posedge core_clk)
    disable iff (!rst_n)
    (busy && c_r.dirNeg) |-> c_r.op == OP_MOVE)
    else $error("negative direction on an operation other than move");

  chk_solid_colour: assert property (@(posedge core_clk)
    disable iff (!rst_n)
    (memReq && memCmd.we && c_r.op == OP_SOLID) |->
    (memCmd.wdata[7:0] == c_r.fg[7:0]) &&
    (!c_r.bpp16 || memCmd.wdata == c_r.fg))
    else $error("solid fill wrote wrong colour");

  chk_key_skip: assert property (@(posedge core_clk)
    disable iff (!rst_n)
    (memReq && memCmd.we && isTrans) |-> !keyHit)
    else $error("key coloured pixel was written");

  chk_exp_colour: assert property (@(posedge core_clk)
    disable iff (!rst_n)
    (memReq && memCmd.we && isExp) |->
    (curBit_r ? memCmd.wdata[7:0] == c_r.fg[7:0] :
    (!c_r.bgTransp && memCmd.wdata[7:0] == c_r.bg[7:0])))
    else $error("expansion colour wrong");

  chk_pat_wrap: assert property (@(posedge core_clk)
    disable iff (!rst_n)
    (state_r == S_NEXT && lineEnd && patY_r == PAT_LAST) |=>
    patY_r == 3'h0 && patX_r == patX0_r)
    else $error("pattern row did not wrap");

  chk_line_discard: assert property (@(posedge core_clk)
    disable iff (!rst_n)
    (state_r == S_NEXT && lineEnd && isExp) |=> srcLeft_r == LEFT_NONE)
    else $error("leftover expansion bits kept across line");

  chk_exp_order: assert property (@(posedge core_clk)
    disable iff (!rst_n)
    (state_r == S_SRC && consume && isExp) |=>
    curBit_r == $past(srcWord_r[DW-1]))
    else $error("expansion bit order wrong");

  chk_read_pop: assert property (@(posedge core_clk)
    disable iff (!rst_n)
    (hostRe && hostAddr[WIN_BIT] && !hostAddr[0] && hostRdValid) |=>
    !hostRdValid)
    else $error("window read did not take the word");

  chk_mem_hold: assert property (@(posedge core_clk)
    disable iff (!rst_n)
    (memReq && !memAck) |=> memReq && $stable(memCmd))
    else $error("memory request changed before acknowledge");
endmodule
`default_nettype wire

// file: dv/b2e_mem_model.sv
// Display memory model answering the engine's memory port
`timescale 1ns/1ps
`default_nettype none
module b2e_mem_model
  import b2e_pkg::*;
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // Answer delay in cycles
  input wire logic [3:0] waitCycles,
  // Memory port
  input wire logic memReq,
  input wire b2e_mem_type memCmd,
  output logic memAck,
  output logic [DW-1:0] memRdata
);
  logic [7:0] mem [0:4095];
  logic [3:0] waitCnt;
  logic [11:0] wa;

  assign wa = {memCmd.addr[11:1], 1'b0};

  // Read data is only meaningful with the acknowledge; it toggles otherwise
  always @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      memAck <= 1'b0;
      waitCnt <= 4'h0;
      memRdata <= 16'h0000;
    end
    else if (memReq && !memAck && waitCnt >= waitCycles)
    begin
      memAck <= 1'b1;
      waitCnt <= 4'h0;
      memRdata <= {mem[wa + 12'h1], mem[wa]};
      if (memCmd.we && memCmd.be[0])
        mem[wa] <= memCmd.wdata[7:0];
      if (memCmd.we && memCmd.be[1])
        mem[wa + 12'h1] <= memCmd.wdata[15:8];
    end
    else
    begin
      memAck <= 1'b0;
      memRdata <= ~memRdata;
      if (memReq && !memAck)
        waitCnt <= waitCnt + 4'h1;
    end
  end
endmodule
`default_nettype wire

// file: dv/tb_b2e_engine.sv
// Self-checking bench for the 2D block transfer engine
`timescale 1ns/1ps
`default_nettype none
module tb_b2e_engine
  import b2e_pkg::*;
;
  logic core_clk, rst_n, start, busy, hostWe, hostRe;
  logic hostWrReady, hostRdValid, memReq, memAck, sawFull;
  b2e_cfg_type cfg;
  b2e_mem_type memCmd;
  logic [AW-1:0] hostAddr;
  logic [DW-1:0] hostWdata, hostRdata, memRdata, rd;
  logic [3:0] waitCycles;
  int mismatches;
  int checked;

  b2e_engine dut (.core_clk(core_clk), .rst_n(rst_n), .start(start),
    .cfg(cfg), .busy(busy), .hostWe(hostWe), .hostRe(hostRe),
    .hostAddr(hostAddr), .hostWdata(hostWdata),
    .hostWrReady(hostWrReady), .hostRdValid(hostRdValid),
    .hostRdata(hostRdata), .memReq(memReq), .memCmd(memCmd),
    .memAck(memAck), .memRdata(memRdata));

  b2e_mem_model mm (.core_clk(core_clk), .rst_n(rst_n),
    .waitCycles(waitCycles), .memReq(memReq), .memCmd(memCmd),
    .memAck(memAck), .memRdata(memRdata));

  task automatic test_done();
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  task automatic cmp(input string n, input logic [15:0] e,
                     input logic [15:0] g);
    checked++;
    if (g !== e)
    begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask

  function automatic logic [15:0] m16(input int a);
    return {mm.mem[a + 1], mm.mem[a]};
  endfunction

  // Expected two-operand result for host 00ff over destination 0f0f
  function automatic logic [15:0] ropf(input logic [3:0] r);
    logic [15:0] s, d, y;
    s = 16'h00ff;
    d = 16'h0f0f;
    for (int i = 0; i < 16; i++)
      y[i] = r[{s[i], d[i]}];
    return y;
  endfunction

  function automatic b2e_cfg_type mk(input b2e_op_type o, input logic b16,
    input logic [AW-1:0] s, input logic [AW-1:0] d,
    input logic [CW-1:0] w, input logic [CW-1:0] h);
    b2e_cfg_type c;
    c = '0;
    c.op = o;
    c.rop = 4'hc;
    c.bpp16 = b16;
    c.srcAddr = s;
    c.dstAddr = d;
    c.srcPitch = 21'h000020;
    c.dstPitch = 21'h000020;
    c.width = w;
    c.height = h;
    c.fg = 16'hf00d;
    c.bg = 16'hb0b0;
    return c;
  endfunction

  task automatic clr();
    for (int i = 0; i < 4096; i++)
      mm.mem[i] = 8'hee;
  endtask

  task automatic run(input b2e_cfg_type c);
    @(negedge core_clk);
    cfg = c;
    start = 1'b1;
    @(negedge core_clk);
    start = 1'b0;
    cmp("busy", 16'h1, {15'h0, busy});
  endtask

  task automatic idle();
    int n;
    n = 0;
    while (busy !== 1'b0 && n < 4000)
    begin
      @(negedge core_clk);
      n++;
    end
    cmp("idle", 16'h0, {15'h0, busy});
  endtask

  task automatic hwr(input logic [AW-1:0] a, input logic [DW-1:0] d);
    int n;
    n = 0;
    @(negedge core_clk);
    hostAddr = a;
    hostWdata = d;
    hostWe = 1'b1;
    while (hostWrReady !== 1'b1 && n < 2000)
    begin
      @(negedge core_clk);
      n++;
    end
    @(negedge core_clk);
    hostWe = 1'b0;
  endtask

  task automatic hrd(input logic [AW-1:0] a);
    int n;
    n = 0;
    @(negedge core_clk);
    hostAddr = a;
    hostRe = 1'b1;
    while (hostRdValid !== 1'b1 && n < 2000)
    begin
      @(negedge core_clk);
      n++;
    end
    rd = hostRdata;
    @(negedge core_clk);
    hostRe = 1'b0;
  endtask

  // Records that the write FIFO refused while an operation ran
  always @(negedge core_clk)
    if (busy === 1'b1 && hostWrReady === 1'b0)
      sawFull = 1'b1;

  initial
  begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end

  initial
  begin
    #1000000;
    mismatches++;
    test_done();
  end

  initial
  begin
    b2e_cfg_type c;
    logic [15:0] e;
    logic [7:0] b;
    rst_n = 1'b0;
    start = 1'b0;
    hostWe = 1'b0;
    hostRe = 1'b0;
    hostAddr = '0;
    hostWdata = '0;
    cfg = '0;
    waitCycles = 4'h0;
    sawFull = 1'b0;
    rd = '0;
    clr();
    repeat (12) @(negedge core_clk);
    cmp("rstReady", 16'h0, {15'h0, hostWrReady});
    cmp("rstReq", 16'h0, {15'h0, memReq});
    rst_n = 1'b1;
    @(negedge core_clk);
    cmp("ready", 16'h1, {15'h0, hostWrReady});
    // Solid fill at 8 bpp from an odd byte
    run(mk(OP_SOLID, 1'b0, '0, 21'h000101, 10'h3, 10'h1));
    idle();
    for (int i = 0; i < 5; i++)
      cmp("solid", (i == 0 || i == 4) ? 16'h00ee : 16'h000d,
        {8'h0, mm.mem[256 + i]});
    for (int r = 0; r < 16; r++)
    begin
      c = mk(OP_WRITE, 1'b1, '0, 21'h000200, 10'h1, 10'h1);
      c.rop = r[3:0];
      mm.mem[512] = 8'h0f;
      mm.mem[513] = 8'h0f;
      run(c);
      hwr(21'h100000, 16'h00ff);
      idle();
      cmp("rop", ropf(r[3:0]), m16(512));
    end
    // Slow memory lets the host fill the write FIFO
    waitCycles = 4'hf;
    run(mk(OP_WRITE, 1'b1, '0, 21'h000300, 10'd12, 10'h1));
    for (int i = 0; i < 12; i++)
      hwr(21'h1ffffe, 16'h1000 + 16'(i));
    idle();
    cmp("fifoFull", 16'h1, {15'h0, sawFull});
    for (int i = 0; i < 12; i++)
      cmp("fifoData", 16'h1000 + 16'(i), m16(768 + 2 * i));
    waitCycles = 4'h2;
    run(mk(OP_READ, 1'b1, 21'h000300, '0, 10'h2, 10'h1));
    @(negedge core_clk);
    hostAddr = 21'h100001;
    hostRe = 1'b1;
    repeat (40) @(negedge core_clk);
    cmp("oddRead", 16'h1, {15'h0, hostRdValid});
    hostRe = 1'b0;
    hrd(21'h1ffffe);
    cmp("read0", 16'h1000, rd);
    hrd(21'h100000);
    cmp("read1", 16'h1001, rd);
    idle();
    c = mk(OP_MOVE, 1'b1, 21'h000302, 21'h000582, 10'h2, 10'h1);
    c.dirNeg = 1'b1;
    run(c);
    idle();
    cmp("moveNeg", 16'h1000, m16(1408));
    cmp("moveNeg", 16'h1001, m16(1410));
    for (int t = 0; t < 2; t++)
    begin
      clr();
      c = mk(OP_EXP, 1'b1, '0, 21'h000500, 10'h3, 10'h2);
      c.bgTransp = t[0];
      run(c);
      hwr(21'h100000, 16'hffa0);
      hwr(21'h100000, 16'h0040);
      idle();
      for (int p = 0; p < 6; p++)
      begin
        e = (p % 2 == 0) ? 16'hf00d : (t == 1 ? 16'heeee : 16'hb0b0);
        cmp("expand", e,
          m16(1280 + (p / 3) * 32 + (p % 3) * 2));
      end
    end
    clr();
    for (int i = 0; i < 64; i++)
      mm.mem[1024 + i] = 8'h80 + 8'(i);
    run(mk(OP_PAT, 1'b0, 21'h00043e, 21'h000600, 10'h3, 10'h2));
    idle();
    for (int p = 0; p < 8; p++)
    begin
      e = (p % 4 == 3) ? 16'h00ee :
        16'(128 + ((7 + p / 4) % 8) * 8 + (6 + p % 4) % 8);
      cmp("pattern", e,
        {8'h0, mm.mem[1536 + (p / 4) * 32 + p % 4]});
    end
    c = mk(OP_TWRITE, 1'b1, '0, 21'h000700, 10'h3, 10'h1);
    c.rop = 4'h0;
    c.bg = 16'h1234;
    run(c);
    hwr(21'h100000, 16'haaaa);
    hwr(21'h100000, 16'h1234);
    hwr(21'h100000, 16'h5555);
    idle();
    cmp("twrite", 16'haaaa, m16(1792));
    cmp("twrite", 16'heeee, m16(1794));
    cmp("twrite", 16'h5555, m16(1796));
    // Transparent move asks for negative stepping, which must be ignored
    c = mk(OP_TMOVE, 1'b1, 21'h000700, 21'h000780, 10'h3, 10'h1);
    c.dirNeg = 1'b1;
    c.bg = 16'h5555;
    run(c);
    idle();
    cmp("tmove", 16'haaaa, m16(1920));
    cmp("tmove", 16'heeee, m16(1922));
    cmp("tmove", 16'heeee, m16(1924));
    // Move expansion from off-screen bytes, one byte per line
    mm.mem[1984] = 8'ha5;
    mm.mem[2016] = 8'h3c;
    run(mk(OP_MEXP, 1'b0, 21'h0007c0, 21'h000800, 10'h4, 10'h2));
    idle();
    for (int p = 0; p < 8; p++)
    begin
      b = (p < 4) ? 8'ha5 : 8'h3c;
      e = b[7 - p % 4] ? 16'h000d : 16'h00b0;
      cmp("mexp", e,
        {8'h0, mm.mem[2048 + (p / 4) * 32 + p % 4]});
    end
    // Read at 8 bpp packs two pixels, the odd last one alone
    run(mk(OP_READ, 1'b0, 21'h000400, '0, 10'h3, 10'h1));
    hrd(21'h100000);
    cmp("read8", 16'h8180, rd);
    hrd(21'h100000);
    cmp("read8", 16'h0082, rd);
    idle();
    test_done();
  end
endmodule
`default_nettype wire
